// ===== rtl/fcs_cfg.svh
/*
 Register offsets, field positions, reset values and timing counts of the
 clock source mode controller. Definitions only; included by bare name.
*/
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH

`define FCS_CLK_NS      50
`define FCS_DIV_W       7

`define FCS_OFF_CTRL1   3'h0
`define FCS_OFF_CTRL2   3'h1
`define FCS_OFF_CTRL4   3'h3
`define FCS_OFF_STAT    3'h4
`define FCS_OFF_OSC     3'h6

`define FCS_CTRL1_RST   8'h04
`define FCS_CTRL2_RST   8'h20
`define FCS_CTRL4_RST   8'h00
`define FCS_OSC_RST     8'h00

`define FCS_C1_CLK_SOURCE_SEL     7:6
`define FCS_C1_REF_DIV_SEL     5:3
`define FCS_C1_REFSEL   2
`define FCS_C1_INT_REF_OUT_EN  1
`define FCS_C1_IRSTEN   0
`define FCS_C2_OUT_DIV_SEL     7:5
`define FCS_C2_LP       3
`define FCS_C4_LOCK_LOST_IRQ_EN    7
`define FCS_C4_CME      5
`define FCS_S_LOCK_LOST_FLAG      7
`define FCS_S_LOCK      6
`define FCS_S_REFST     4
`define FCS_S_CLK_SOURCE_STATUS     3:2
`define FCS_S_FFE       1
`define FCS_S_CLKRST    0
`define FCS_O_XEN       7
`define FCS_O_XSTEN     5
`define FCS_O_RANGE     4

`define FCS_FFE_MIN_GAP 3'h2
`define FCS_FFE_MAX_BD  3'h3

`define FCS_LOC_HI_NS   5000
`define FCS_LOC_LO_NS   100000
`define FCS_LOC_HI_CYC  ((`FCS_LOC_HI_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_LOC_LO_CYC  ((`FCS_LOC_LO_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_LOC_W       12

`endif

// ===== rtl/fcs_pkg.sv
/*
 Types of the clock source mode controller.
 Assumes fcs_cfg.svh holds all numeric constants.
*/
package fcs_pkg;
	typedef enum logic [2:0] {
		fll_int_mode,
		fll_ext_mode,
		bypass_int_mode,
		bypass_int_lowpwr_mode,
		bypass_ext_mode,
		bypass_ext_lowpwr_mode,
		stop_mode
	} fcs_mode_t;

	typedef enum logic [1:0] {
		src_fll,
		src_int,
		src_ext,
		src_none
	} fcs_src_sel_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} fcs_bus_t;

	typedef struct packed {
		logic digital_osc;
		logic int_ref;
		logic ext_ref;
	} fcs_raw_clk_t;
endpackage

// ===== rtl/fcs_pow2_div.sv
/*
 Power-of-two divider of a sampled clock level.
 Assumes src_lvl is already synchronised and src_rise marks its rising edge.
*/
`timescale 1ns/1ps
`include "fcs_cfg.svh"
module fcs_pow2_div (
	input  wire logic       clock,   // system clock
	input  wire logic       rst_n,   // sync reset, low
	input  wire logic       run,     // divider enabled
	input  wire logic       src_lvl, // sampled source level
	input  wire logic       src_rise,// source rising edge
	input  wire logic [2:0] sel,     // divide by 2**sel
	output logic            div_out  // divided level
);
	logic [`FCS_DIV_W-1:0] cnt_q, cnt_d;
	logic                  out_q, out_d;

	always_comb begin
		cnt_d = cnt_q;
		if (!run)
			cnt_d = '0;
		else if (src_rise)
			cnt_d = cnt_q + `FCS_DIV_W'(1);
		// Selection read live so a new code acts at once
		if (!run)
			out_d = 1'b0;
		else if (sel == 3'h0)
			out_d = src_lvl;
		else
			out_d = cnt_q[3'(sel - 3'h1)];
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cnt_q <= '0;
			out_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign div_out = out_q;
endmodule

// ===== rtl/fcs_top.sv
/*
 Clock source mode controller: mode tracking, source switching, output
 divider, fixed-frequency and debug clocks, lock-loss flag, clock monitor.
 Assumes raw clocks arrive from other domains and are far slower than clock;
 the core, stop request and debug controller share this clock.
*/
`timescale 1ns/1ps
`include "fcs_cfg.svh"

module fcs_top (
	input  wire logic                 clock,             // 20 MHz system clock
	input  wire logic                 rst_n,             // sync reset, low
	input  wire fcs_pkg::fcs_bus_t    bus,               // register request
	output logic [7:0]                rdata,             // read data, next cycle
	input  wire fcs_pkg::fcs_raw_clk_t raw_clk,          // raw source clocks
	input  wire logic                 fll_locked,        // analog lock indication
	input  wire logic                 ext_ref_ok,        // external reference ready
	input  wire logic                 debug_mode_active, // debug session active
	input  wire logic                 stop_req,          // MCU in stop
	output logic                      core_clock_out,    // divided system clock
	output logic                      fixed_freq_clk,    // FLL reference, divided only when external
	output logic                      fixed_freq_valid,  // fixed clock usable
	output logic                      debug_comm_clock,  // oscillator halved
	output logic                      int_ref_clk_out,   // internal reference out
	output logic                      xosc_out,          // oscillator out
	output logic                      fll_enable,        // FLL powered
	output logic                      fll_restart,       // relock pulse
	output logic                      lock_lost_irq,     // lock-loss interrupt
	output logic                      clock_loss_reset,  // reset request pulse
	output fcs_pkg::fcs_mode_t        mode               // current mode
);
	import fcs_pkg::*;

	logic [4:0] s1_q, s2_q, s3_q;
	logic       dco_l, int_l, ext_l, lock_l, extok_l;
	logic       dco_r, ext_r;
	logic [7:0] c1_q, c1_d, c2_q, c2_d, c4_q, c4_d, osc_q, osc_d;
	logic [7:0] rd_q, rd_d;
	fcs_src_sel_t cs_q, cs_d, req_src;
	logic       refx_q, refx_d;
	fcs_mode_t  mode_q, mode_d;
	logic       lock_lost_flag_q, lock_lost_flag_d, clkrst_q, clkrst_d;
	logic [`FCS_LOC_W-1:0] mon_q, mon_d;
	logic       crst_q, crst_d, rst_pulse_q, rst_pulse_d;
	logic       dbg_q, dbg_d, ffv_q, ffv_d, ffc_q, ffc_d;
	logic       irc_q, irc_d, xo_q, xo_d, fen_q, fen_d;
	logic       sel_lvl, core_div, ref_div, lp_req, src_ok;
	logic       lock_act, mon_act, stat_wr;
	logic [`FCS_LOC_W-1:0] mon_thr;

	function automatic logic low_pwr(input fcs_mode_t m);
		return (m == bypass_int_lowpwr_mode) || (m == bypass_ext_lowpwr_mode);
	endfunction

	function automatic logic src_lvl_of(input fcs_src_sel_t s, input logic d,
		input logic i, input logic e);
		case (s)
			src_fll: return d;
			src_int: return i;
			src_ext: return e;
			default: return 1'b0;
		endcase
	endfunction

	// Sampled-only inputs; third stage only feeds edge detection
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= {ext_ref_ok, fll_locked, raw_clk};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign ext_l   = s2_q[0];
	assign int_l   = s2_q[1];
	assign dco_l   = s2_q[2];
	assign lock_l  = s2_q[3];
	assign extok_l = s2_q[4];
	assign ext_r   = s2_q[0] & ~s3_q[0];
	assign dco_r   = s2_q[2] & ~s3_q[2];

	assign sel_lvl = src_lvl_of(cs_q, dco_l, int_l, ext_l);

	fcs_pow2_div u_core_div (
		.clock    (clock),
		.rst_n    (rst_n),
		.run      (mode_q != stop_mode),
		.src_lvl  (sel_lvl),
		.src_rise (sel_lvl & ~src_lvl_of(cs_q, s3_q[2], s3_q[1], s3_q[0])),
		.sel      (c2_q[`FCS_C2_OUT_DIV_SEL]),
		.div_out  (core_div)
	);

	fcs_pow2_div u_ref_div (
		.clock    (clock),
		.rst_n    (rst_n),
		.run      (!refx_q ? 1'b0 : mode_q != stop_mode),
		.src_lvl  (ext_l),
		.src_rise (ext_r),
		.sel      (c1_q[`FCS_C1_REF_DIV_SEL]),
		.div_out  (ref_div)
	);

	assign lp_req   = c2_q[`FCS_C2_LP] & ~debug_mode_active;
	assign lock_act = (mode_q != stop_mode) && !low_pwr(mode_q);
	assign mon_act  = c4_q[`FCS_C4_CME] && ((mode_q == bypass_ext_mode) ||
		(mode_q == fll_ext_mode) || (mode_q == bypass_int_mode));
	assign mon_thr  = osc_q[`FCS_O_RANGE] ? `FCS_LOC_W'(`FCS_LOC_HI_CYC)
		: `FCS_LOC_W'(`FCS_LOC_LO_CYC);
	assign stat_wr  = bus.wr && (bus.addr == `FCS_OFF_STAT);

	always_comb begin
		c1_d  = c1_q;
		c2_d  = c2_q;
		c4_d  = c4_q;
		osc_d = osc_q;
		if (bus.wr) begin
			case (bus.addr)
				`FCS_OFF_CTRL1: c1_d  = bus.wdata;
				`FCS_OFF_CTRL2: c2_d  = bus.wdata;
				`FCS_OFF_CTRL4: c4_d  = bus.wdata;
				`FCS_OFF_OSC:   osc_d = bus.wdata;
				default: ;
			endcase
		end
		rd_d = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				`FCS_OFF_CTRL1: rd_d = c1_q;
				`FCS_OFF_CTRL2: rd_d = c2_q;
				`FCS_OFF_CTRL4: rd_d = c4_q;
				`FCS_OFF_OSC:   rd_d = osc_q;
				`FCS_OFF_STAT: begin
					rd_d[`FCS_S_LOCK_LOST_FLAG]   = lock_lost_flag_q;
					rd_d[`FCS_S_LOCK]   = lock_l & lock_act;
					rd_d[`FCS_S_REFST]  = ~refx_q;
					rd_d[`FCS_S_CLK_SOURCE_STATUS]  = cs_q;
					rd_d[`FCS_S_FFE]    = ffv_q;
					rd_d[`FCS_S_CLKRST] = clkrst_q;
				end
				default: rd_d = 8'h00;
			endcase
		end
	end

	// Source and reference tracking, mode derivation
	always_comb begin
		case (c1_q[`FCS_C1_CLK_SOURCE_SEL])
			2'h0:    req_src = src_fll;
			2'h1:    req_src = src_int;
			2'h2:    req_src = src_ext;
			default: req_src = cs_q;
		endcase
		src_ok = (req_src != src_ext) || extok_l;
		cs_d = cs_q;
		// Swap only while both levels are low, so no runt pulse escapes
		if (req_src != cs_q && src_ok && !sel_lvl &&
			!src_lvl_of(req_src, dco_l, int_l, ext_l))
			cs_d = req_src;
		refx_d = refx_q;
		if (c1_q[`FCS_C1_REFSEL])
			refx_d = 1'b0;
		else if (extok_l)
			refx_d = 1'b1;
		if (stop_req)
			mode_d = stop_mode;
		else begin
			case (cs_q)
				src_int: mode_d = lp_req ? bypass_int_lowpwr_mode
					: bypass_int_mode;
				src_ext: mode_d = lp_req ? bypass_ext_lowpwr_mode
					: bypass_ext_mode;
				default: mode_d = refx_q ? fll_ext_mode : fll_int_mode;
			endcase
		end
	end

	// Lock flag, clock monitor and clock outputs
	always_comb begin
		lock_lost_flag_d = lock_lost_flag_q;
		if (stat_wr && bus.wdata[`FCS_S_LOCK_LOST_FLAG] && lock_lost_flag_q)
			lock_lost_flag_d = 1'b0;
		if (lock_act && !lock_l && s3_q[3])
			lock_lost_flag_d = 1'b1;
		mon_d = mon_q;
		rst_pulse_d = 1'b0;
		if (!mon_act || ext_r)
			mon_d = '0;
		else if (mon_q >= mon_thr - `FCS_LOC_W'(1)) begin
			mon_d = '0;
			rst_pulse_d = 1'b1;
		end else
			mon_d = mon_q + `FCS_LOC_W'(1);
		clkrst_d = clkrst_q;
		if (stat_wr && bus.wdata[`FCS_S_CLKRST])
			clkrst_d = 1'b0;
		if (rst_pulse_d)
			clkrst_d = 1'b1;
		crst_d = (mode_q == stop_mode) && (mode_d != stop_mode);
		if (mode_q == fll_int_mode && mode_d == fll_ext_mode)
			crst_d = 1'b1;
		if (mode_q == fll_ext_mode && mode_d == fll_int_mode)
			crst_d = 1'b1;
		fen_d = lock_act;
		dbg_d = 1'b0;
		if (lock_act && dco_r)
			dbg_d = ~dbg_q;
		else if (lock_act)
			dbg_d = dbg_q;
		case (mode_q)
			fll_int_mode, fll_ext_mode: ffv_d = 1'b1;
			bypass_ext_mode, bypass_ext_lowpwr_mode:
				ffv_d = osc_q[`FCS_O_RANGE] &&
					(c2_q[`FCS_C2_OUT_DIV_SEL] <= `FCS_FFE_MAX_BD) &&
					(c1_q[`FCS_C1_REF_DIV_SEL] >= c2_q[`FCS_C2_OUT_DIV_SEL] + `FCS_FFE_MIN_GAP);
			default: ffv_d = 1'b0;
		endcase
		ffc_d = 1'b0;
		if (mode_q != stop_mode)
			ffc_d = refx_q ? ref_div : int_l;
		irc_d = c1_q[`FCS_C1_INT_REF_OUT_EN] && (mode_q != stop_mode ||
			c1_q[`FCS_C1_IRSTEN]) && int_l;
		xo_d = osc_q[`FCS_O_XEN] && (mode_q != stop_mode ||
			osc_q[`FCS_O_XSTEN]) && ext_l;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			c1_q        <= `FCS_CTRL1_RST;
			c2_q        <= `FCS_CTRL2_RST;
			c4_q        <= `FCS_CTRL4_RST;
			osc_q       <= `FCS_OSC_RST;
			rd_q        <= 8'h00;
			cs_q        <= src_fll;
			refx_q      <= 1'b0;
			mode_q      <= fll_int_mode;
			lock_lost_flag_q      <= 1'b0;
			clkrst_q    <= 1'b0;
			mon_q       <= '0;
			rst_pulse_q <= 1'b0;
			crst_q      <= 1'b0;
			fen_q       <= 1'b1;
			dbg_q       <= 1'b0;
			ffv_q       <= 1'b0;
			ffc_q       <= 1'b0;
			irc_q       <= 1'b0;
			xo_q        <= 1'b0;
		end else begin
			c1_q        <= c1_d;
			c2_q        <= c2_d;
			c4_q        <= c4_d;
			osc_q       <= osc_d;
			rd_q        <= rd_d;
			cs_q        <= cs_d;
			refx_q      <= refx_d;
			mode_q      <= mode_d;
			lock_lost_flag_q      <= lock_lost_flag_d;
			clkrst_q    <= clkrst_d;
			mon_q       <= mon_d;
			rst_pulse_q <= rst_pulse_d;
			crst_q      <= crst_d;
			fen_q       <= fen_d;
			dbg_q       <= dbg_d;
			ffv_q       <= ffv_d;
			ffc_q       <= ffc_d;
			irc_q       <= irc_d;
			xo_q        <= xo_d;
		end
	end

	assign rdata            = rd_q;
	assign core_clock_out   = core_div;
	assign fixed_freq_clk   = ffc_q;
	assign fixed_freq_valid = ffv_q;
	assign debug_comm_clock = dbg_q;
	assign int_ref_clk_out  = irc_q;
	assign xosc_out         = xo_q;
	assign fll_enable       = fen_q;
	assign fll_restart      = crst_q;
	assign clock_loss_reset = rst_pulse_q;
	assign mode             = mode_q;
	// fll_int_mode and bypass_int_mode interrupt regardless of the enable bit
	assign lock_lost_irq    = lock_lost_flag_q && (c4_q[`FCS_C4_LOCK_LOST_IRQ_EN] ||
		mode_q == fll_int_mode || mode_q == bypass_int_mode);

	a_lol_set: assert property (@(posedge clock) disable iff (!rst_n)
		(lock_act && !lock_l && s3_q[3]) |=> lock_lost_flag_q)
		else $error("lock loss not flagged");

	a_lol_w0: assert property (@(posedge clock) disable iff (!rst_n)
		(stat_wr && !bus.wdata[`FCS_S_LOCK_LOST_FLAG] && lock_lost_flag_q) |=> lock_lost_flag_q)
		else $error("lock flag cleared by zero write");

	a_stop_core: assert property (@(posedge clock) disable iff (!rst_n)
		(mode_q == stop_mode) [*2] |=> !core_clock_out)
		else $error("system clock runs in stop");

	a_dbg_lowpwr: assert property (@(posedge clock) disable iff (!rst_n)
		low_pwr(mode_q) |=> !debug_comm_clock)
		else $error("debug clock in low power mode");

	a_mon_lowpwr: assert property (@(posedge clock) disable iff (!rst_n)
		low_pwr(mode_q) [*2] |-> !clock_loss_reset)
		else $error("monitor acts in low power mode");

	a_ffe_bypint: assert property (@(posedge clock) disable iff (!rst_n)
		(mode_q == bypass_int_mode) |=> !fixed_freq_valid)
		else $error("fixed clock valid in internal bypass");

	a_src_keep: assert property (@(posedge clock) disable iff (!rst_n)
		(req_src == src_ext && !extok_l) |=> $stable(cs_q) || cs_q != src_ext)
		else $error("switched to unavailable source");

	a_mon_fire: assert property (@(posedge clock) disable iff (!rst_n)
		(mon_act && !ext_r && mon_q == mon_thr - `FCS_LOC_W'(1))
		|=> clock_loss_reset ##1 clkrst_q)
		else $error("clock monitor did not fire");

	a_stop_ir: assert property (@(posedge clock) disable iff (!rst_n)
		(mode_q == stop_mode && !c1_q[`FCS_C1_IRSTEN]) |=> !int_ref_clk_out)
		else $error("reference output runs in stop");

	a_restart: assert property (@(posedge clock) disable iff (!rst_n)
		(mode_q == stop_mode && !stop_req) |=> fll_restart)
		else $error("no relock after stop");
endmodule

// ===== verif/fcs_clk_partner.sv
/*
 Behavioural far side of the clock source controller: raw oscillator,
 internal and external reference clocks and the analog lock indication.
 Assumes the bench steers reference stoppage, range and lock loss.
*/
`timescale 1ns/1ps
module fcs_clk_partner (
	input  wire logic             ext_run,    // external reference running
	input  wire logic             ext_ok,     // reference within range
	input  wire logic             lock_ok,    // FLL holds lock
	output fcs_pkg::fcs_raw_clk_t raw_clk,    // raw clocks
	output logic                  fll_locked, // lock indication
	output logic                  ext_ref_ok  // reference usable
);
	import fcs_pkg::*;
	logic osc = 1'b0;
	logic iref = 1'b0;
	logic xref = 1'b0;
	// Half periods never land on a rising sampling edge
	always #200 osc = ~osc;
	always #400 iref = ~iref;
	// Stopped reference stands low, as a dead crystal would
	always #600 xref = ext_run ? ~xref : 1'b0;
	assign raw_clk = '{digital_osc: osc, int_ref: iref, ext_ref: xref};
	assign fll_locked = lock_ok;
	assign ext_ref_ok = ext_ok;
endmodule

// ===== verif/fcs_tb.sv
/*
 Self-checking bench of the clock source mode controller.
 Assumes fcs_top, fcs_pkg and the behavioural clock partner.
*/
`timescale 1ns/1ps
module tb;
	import fcs_pkg::*;
	typedef struct packed {
		logic [7:0] c1;
		logic [7:0] c2;
		logic       dbg;
		fcs_mode_t  m;
		logic [7:0] st;
		logic       fen;
		logic       ffv;
	} fcs_row_t;
	logic         clock = 1'b0;
	logic         rst_n = 1'b0;
	fcs_bus_t     bus = '0;
	logic         dbg = 1'b0;
	logic         stop_req = 1'b0;
	logic         ext_run = 1'b1;
	logic         ext_ok = 1'b1;
	logic         lock_ok = 1'b1;
	logic         rs;
	logic [7:0]   rdata;
	fcs_raw_clk_t raw_clk;
	logic         fll_locked, ext_ref_ok, core_clock_out, fixed_freq_clk, fixed_freq_valid;
	logic         debug_comm_clock, int_ref_clk_out, xosc_out, fll_enable, fll_restart;
	logic         lock_lost_irq, clock_loss_reset;
	fcs_mode_t    mode;
	int           num_errors = 0;
	int           n_compared = 0;
	int           tg [6];
	fcs_row_t     rows [8] = '{
		'{8'h04, 8'h00, 1'b0, fll_int_mode, 8'h10, 1'b1, 1'b1},
		'{8'h44, 8'h00, 1'b0, bypass_int_mode, 8'h14, 1'b1, 1'b0},
		'{8'h44, 8'h08, 1'b0, bypass_int_lowpwr_mode, 8'h14, 1'b0, 1'b0},
		'{8'h44, 8'h08, 1'b1, bypass_int_mode, 8'h14, 1'b1, 1'b0},
		'{8'h80, 8'h00, 1'b0, bypass_ext_mode, 8'h08, 1'b1, 1'b0},
		'{8'h80, 8'h08, 1'b0, bypass_ext_lowpwr_mode, 8'h08, 1'b0, 1'b0},
		'{8'h00, 8'h00, 1'b0, fll_ext_mode, 8'h00, 1'b1, 1'b1},
		'{8'h04, 8'h00, 1'b0, fll_int_mode, 8'h10, 1'b1, 1'b1}};

	fcs_clk_partner far (.ext_run(ext_run), .ext_ok(ext_ok), .lock_ok(lock_ok),
		.raw_clk(raw_clk), .fll_locked(fll_locked), .ext_ref_ok(ext_ref_ok));
	fcs_top uut (.clock(clock), .rst_n(rst_n), .bus(bus), .rdata(rdata), .raw_clk(raw_clk),
		.fll_locked(fll_locked), .ext_ref_ok(ext_ref_ok), .debug_mode_active(dbg),
		.stop_req(stop_req), .core_clock_out(core_clock_out), .fixed_freq_clk(fixed_freq_clk),
		.fixed_freq_valid(fixed_freq_valid), .debug_comm_clock(debug_comm_clock),
		.int_ref_clk_out(int_ref_clk_out), .xosc_out(xosc_out), .fll_enable(fll_enable),
		.fll_restart(fll_restart), .lock_lost_irq(lock_lost_irq),
		.clock_loss_reset(clock_loss_reset), .mode(mode));

	always #25 clock = ~clock;

	task automatic stop_test;
		$display("errors %0d of %0d compares", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock);
		bus <= '0;
	endtask

	task automatic bus_rd(input logic [2:0] a, input logic [7:0] msk, input logic [7:0] exp);
		@(posedge clock);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clock);
		bus <= '0;
		#1;
		chk(rdata & msk, exp);
	endtask

	// Bounded wait; a mode that never arrives ends the run
	task automatic wait_mode(input fcs_mode_t m);
		int k;
		rs = 1'b0;
		for (k = 0; k < 400 && mode !== m; k++) begin
			@(posedge clock);
			#1;
			rs = rs | (fll_restart === 1'b1);
		end
		repeat (2) begin
			@(posedge clock);
			#1;
			rs = rs | (fll_restart === 1'b1);
		end
		chk({5'h0, mode}, {5'h0, m});
		if (mode !== m) begin
			stop_test();
		end
	endtask

	// Counts level changes of fixed, core, debug, int ref, oscillator and loss-reset outputs
	task automatic watch(input int n);
		logic [5:0] prev;
		logic [5:0] cur;
		tg = '{default: 0};
		#1;
		prev = {fixed_freq_clk, core_clock_out, debug_comm_clock, int_ref_clk_out, xosc_out,
			clock_loss_reset};
		repeat (n) begin
			@(posedge clock);
			#1;
			cur = {fixed_freq_clk, core_clock_out, debug_comm_clock, int_ref_clk_out, xosc_out,
				clock_loss_reset};
			for (int k = 0; k < 6; k++) begin
				tg[k] += int'(cur[k] != prev[k]);
			end
			prev = cur;
		end
	endtask

	task automatic lose_lock(input logic [7:0] fl, input logic irq);
		@(posedge clock);
		lock_ok <= 1'b0;
		repeat (8) @(posedge clock);
		#1;
		chk({7'h0, lock_lost_irq}, {7'h0, irq});
		bus_rd(3'h4, 8'h80, fl);
		@(posedge clock);
		lock_ok <= 1'b1;
		repeat (8) @(posedge clock);
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		num_errors++;
		stop_test();
	end

	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			@(posedge clock);
			dbg <= rows[i].dbg;
			bus_wr(3'h1, rows[i].c2);
			bus_wr(3'h0, rows[i].c1);
			wait_mode(rows[i].m);
			chk({7'h0, fll_enable}, {7'h0, rows[i].fen});
			bus_rd(3'h4, 8'h1c, rows[i].st);
			watch(64);
			chk({7'h0, tg[3] != 0}, {7'h0, rows[i].fen});
			chk({7'h0, tg[5] != 0}, 8'h01);
			chk({7'h0, fixed_freq_valid}, {7'h0, rows[i].ffv});
			if (i == 7) begin
				chk({7'h0, rs}, 8'h01);
			end
		end
		// Second reset in mid-run
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		chk({5'h0, mode}, {5'h0, fll_int_mode});
		bus_wr(3'h7, 8'hff);
		bus_rd(3'h0, 8'hff, 8'h04);
		bus_rd(3'h1, 8'hff, 8'h20);
		bus_rd(3'h3, 8'hff, 8'h00);
		bus_rd(3'h6, 8'hff, 8'h00);
		bus_rd(3'h7, 8'hff, 8'h00);
		bus_rd(3'h4, 8'h1c, 8'h10);
		// Divider reacts to each code without a mode change
		bus_wr(3'h0, 8'h44);
		wait_mode(bypass_int_mode);
		for (int b = 0; b < 8; b++) begin
			bus_wr(3'h1, {b[2:0], 5'h00});
			watch(2048);
			chk({7'h0, tg[4] >= (256 >> b) - 2 && tg[4] <= (256 >> b) + 2}, 8'h01);
		end
		// Fixed clock validity over every divider pair in external bypass
		bus_wr(3'h6, 8'h10);
		bus_wr(3'h1, 8'h00);
		bus_wr(3'h0, 8'h80);
		wait_mode(bypass_ext_mode);
		for (int b = 0; b < 8; b++) begin
			for (int r = 0; r < 8; r++) begin
				bus_wr(3'h1, {b[2:0], 5'h00});
				bus_wr(3'h0, {2'b10, r[2:0], 3'b000});
				repeat (4) @(posedge clock);
				#1;
				chk({7'h0, fixed_freq_valid}, {7'h0, b < 4 && r >= b + 2});
			end
		end
		bus_wr(3'h0, 8'h80);
		lose_lock(8'h80, 1'b0);
		bus_wr(3'h4, 8'h00);
		bus_rd(3'h4, 8'h80, 8'h80);
		bus_wr(3'h3, 8'h80);
		#1;
		chk({7'h0, lock_lost_irq}, 8'h01);
		bus_wr(3'h4, 8'h80);
		bus_rd(3'h4, 8'h80, 8'h00);
		bus_wr(3'h3, 8'h00);
		bus_wr(3'h0, 8'h44);
		wait_mode(bypass_int_mode);
		lose_lock(8'h80, 1'b1);
		bus_wr(3'h4, 8'h80);
		bus_wr(3'h1, 8'h08);
		wait_mode(bypass_int_lowpwr_mode);
		lose_lock(8'h00, 1'b0);
		// Clock monitor, acting in bypass_ext_mode but not in bypass_ext_lowpwr_mode
		bus_wr(3'h0, 8'h80);
		wait_mode(bypass_ext_lowpwr_mode);
		bus_wr(3'h3, 8'h20);
		ext_run <= 1'b0;
		watch(300);
		chk({7'h0, tg[0] != 0}, 8'h00);
		bus_wr(3'h1, 8'h00);
		wait_mode(bypass_ext_mode);
		watch(300);
		chk({7'h0, tg[0] != 0}, 8'h01);
		bus_rd(3'h4, 8'h01, 8'h01);
		@(posedge clock);
		ext_run <= 1'b1;
		bus_wr(3'h3, 8'h00);
		bus_wr(3'h4, 8'h01);
		bus_rd(3'h4, 8'h01, 8'h00);
		// Stop: only enabled reference and oscillator outputs may run
		bus_wr(3'h0, 8'h06);
		wait_mode(fll_int_mode);
		bus_wr(3'h6, 8'h80);
		stop_req <= 1'b1;
		wait_mode(stop_mode);
		chk({7'h0, fll_enable}, 8'h00);
		watch(64);
		chk({tg[5] != 0, tg[4] != 0, tg[3] != 0, tg[2] != 0, tg[1] != 0, 3'h0}, 8'h00);
		bus_wr(3'h0, 8'h07);
		bus_wr(3'h6, 8'ha0);
		watch(64);
		chk({6'h0, tg[2] != 0, tg[1] != 0}, 8'h03);
		@(posedge clock);
		stop_req <= 1'b0;
		wait_mode(fll_int_mode);
		chk({7'h0, rs}, 8'h01);
		// Unavailable external source is refused and the old one kept
		@(posedge clock);
		ext_ok <= 1'b0;
		bus_wr(3'h0, 8'h80);
		repeat (100) @(posedge clock);
		#1;
		chk({5'h0, mode}, {5'h0, fll_int_mode});
		bus_rd(3'h4, 8'h1c, 8'h10);
		@(posedge clock);
		ext_ok <= 1'b1;
		wait_mode(bypass_ext_mode);
		stop_test();
	end
endmodule
